// ### pkg/rbm_mode_if.sv
`timescale 1ns/1ns
interface rbm_mode_if;
    logic [3:0] code;
    logic valid;
    logic is_active;
    logic is_passive;
    logic is_test;
    logic cpol;
    logic cpha;
    modport capture (output code, valid, is_active, is_passive, is_test,
        output cpol, cpha);
    modport use_side (input code, valid, is_active, is_passive, is_test,
        input cpol, cpha);
endinterface

// ### pkg/rbm_pkg.sv
package rbm_pkg;
    localparam logic [3:0] RBM_SA_LO = 4'h0;
    localparam logic [3:0] RBM_SA_HI = 4'h3;
    localparam logic [3:0] RBM_SP_LO = 4'h4;
    localparam logic [3:0] RBM_SP_HI = 4'h7;
    localparam logic [3:0] RBM_TEST = 4'hc;
    localparam logic [3:0] RBM_MODE_RST = 4'hc;
    localparam int RBM_POL_BIT = 1;
    localparam int RBM_PHA_BIT = 0;
    localparam int RBM_CLK_MHZ = 25;
    localparam int RBM_FAIL_LONG_US = 10;
    localparam int RBM_FAIL_CYC = RBM_FAIL_LONG_US * RBM_CLK_MHZ;

    typedef enum logic [2:0] {
        RBM_SRC_NONE = 3'h0,
        RBM_SRC_ACTIVE = 3'h1,
        RBM_SRC_PASSIVE = 3'h2,
        RBM_SRC_TEST = 3'h3,
        RBM_SRC_USER = 3'h4
    } rbm_src_t;

    typedef enum logic [1:0] {
        RBM_ST_RESET = 2'b00,
        RBM_ST_LOAD = 2'b01,
        RBM_ST_DONE = 2'b11,
        RBM_ST_FAIL = 2'b10
    } rbm_state_t;
endpackage

// ### tb/rbm_flash_model.sv
`timescale 1ns/1ns
module rbm_flash_model #(
    parameter int DELAY = 20
)(
    // Clock
    input wire logic mclk,
    // Device side
    input wire logic flash_read_start,
    input wire logic device_in_reset,
    // Scenario control
    input wire logic fail_next,
    // Load result
    output logic load_ok,
    output logic load_error
);
    int cnt = 0;
    // Answers once per read, and a reset drops a read in flight
    always @(negedge mclk) begin
        load_ok <= 1'b0;
        load_error <= 1'b0;
        if (device_in_reset === 1'b1) begin
            cnt <= 0;
        end else if (flash_read_start === 1'b1) begin
            cnt <= DELAY;
        end else if (cnt == 1) begin
            cnt <= 0;
            load_ok <= !fail_next;
            load_error <= fail_next;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ### tb/reset_and_boot_mode_capture_bench.sv
`timescale 1ns/1ns
module reset_and_boot_mode_capture_bench;
    import rbm_pkg::*;
    localparam int FCYC = 10;
    logic mclk = 1'b0, rstn = 1'b0, reset_pin_n = 1'b0, monitor_enable = 1'b0;
    logic core_supply_ok = 1'b0, clock_supply_ok = 1'b0, fail_next = 1'b0;
    logic user_cfg_request = 1'b0;
    logic [3:0] boot_select_pins = 4'h0;
    logic load_ok, load_error, device_in_reset, serial_cpol, serial_cpha;
    logic flash_read_start, serial_pins_bidir, load_complete, load_fail_n_o;
    logic load_fail_n_oe, serial_forward_out, test_data_output_pin;
    logic [3:0] captured_mode;
    rbm_src_t cfg_source;
    int n_fail = 0, check_count = 0, n_starts = 0;

    rbm_top #(.FAIL_CYC(FCYC)) DUT (.mclk(mclk), .rstn(rstn),
        .reset_pin_n(reset_pin_n), .monitor_enable(monitor_enable),
        .core_supply_ok(core_supply_ok), .clock_supply_ok(clock_supply_ok),
        .boot_select_pins(boot_select_pins),
        .user_cfg_request(user_cfg_request), .load_ok(load_ok),
        .load_error(load_error), .device_in_reset(device_in_reset),
        .captured_mode(captured_mode), .cfg_source(cfg_source),
        .serial_cpol(serial_cpol), .serial_cpha(serial_cpha),
        .flash_read_start(flash_read_start),
        .serial_pins_bidir(serial_pins_bidir), .load_complete(load_complete),
        .load_fail_n_o(load_fail_n_o), .load_fail_n_oe(load_fail_n_oe),
        .serial_forward_out(serial_forward_out),
        .test_data_output_pin(test_data_output_pin));
    rbm_flash_model #(.DELAY(20)) flash (.mclk(mclk),
        .flash_read_start(flash_read_start),
        .device_in_reset(device_in_reset), .fail_next(fail_next),
        .load_ok(load_ok), .load_error(load_error));

    initial begin
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (flash_read_start === 1'b1) n_starts++;
    end

    task automatic wrap_up;
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [3:0] e, logic [3:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // Bounded wait on the reset state; running out ends the run
    task automatic wait_rst(input logic e);
        for (int i = 0; i < 12 && device_in_reset !== e; i++) @(negedge mclk);
        chk("device_in_reset", {3'h0, e}, {3'h0, device_in_reset});
        if (device_in_reset !== e) wrap_up();
    endtask
    // Board pulls the pin low, sets a defined code, then makes a clean edge
    task automatic boot(input logic [3:0] code);
        @(negedge mclk);
        reset_pin_n = 1'b0;
        boot_select_pins = code;
        repeat (6) @(negedge mclk);
        wait_rst(1'b1);
        reset_pin_n = 1'b1;
        wait_rst(1'b0);
    endtask

    task automatic t_reset;
        chk("in_reset", 4'h1, {3'h0, device_in_reset});
        chk("mode", RBM_MODE_RST, captured_mode);
        chk("done", 4'h0, {3'h0, load_complete});
        chk("fail_oe", 4'h0, {3'h0, load_fail_n_oe});
        chk("fwd", 4'h0, {3'h0, serial_forward_out});
        chk("tdo", 4'h0, {3'h0, test_data_output_pin});
    endtask
    task automatic t_modes;
        logic [3:0] c;
        rbm_src_t s;
        int n0;
        for (int i = 0; i < 9; i++) begin
            c = (i == 8) ? RBM_TEST : i[3:0];
            s = c[3] ? RBM_SRC_TEST : (c[2] ? RBM_SRC_PASSIVE : RBM_SRC_ACTIVE);
            n0 = n_starts;
            boot(c);
            repeat (3) @(negedge mclk);
            chk("mode", c, captured_mode);
            chk("src", {1'b0, s}, {1'b0, cfg_source});
            chk("cpol", {3'h0, c[RBM_POL_BIT]}, {3'h0, serial_cpol});
            chk("cpha", {3'h0, c[RBM_PHA_BIT]}, {3'h0, serial_cpha});
            chk("bidir", {3'h0, s == RBM_SRC_ACTIVE},
                {3'h0, serial_pins_bidir});
            chk("starts", (s == RBM_SRC_ACTIVE) ? 4'h1 : 4'h0,
                4'(n_starts - n0));
            chk("busy", 4'h0, {2'h0, load_complete, load_fail_n_oe});
            boot_select_pins = (c == 4'h4) ? 4'h0 : 4'h4;
            repeat (6) @(negedge mclk);
            chk("held", c, captured_mode);
        end
    endtask
    task automatic t_load(input logic f);
        int n;
        fail_next = f;
        boot(4'h1);
        n = 0;
        while (n < 40 && load_complete !== 1'b1) begin
            @(negedge mclk);
            n++;
        end
        chk("done", 4'h1, {3'h0, load_complete});
        chk("fail_o", 4'h0, {3'h0, load_fail_n_o});
        n = 0;
        while (n < 40 && load_fail_n_oe === 1'b1) begin
            @(negedge mclk);
            n++;
        end
        chk("fail_len", f ? 4'(FCYC) : 4'h0, 4'(n));
        chk("done_hold", 4'h1, {3'h0, load_complete});
        fail_next = 1'b0;
    endtask
    task automatic t_monitor;
        monitor_enable = 1'b1;
        boot(4'h4);
        reset_pin_n = 1'b0;
        core_supply_ok = 1'b0;
        repeat (6) @(negedge mclk);
        reset_pin_n = 1'b1;
        repeat (12) @(negedge mclk);
        chk("held_low_sup", 4'h1, {3'h0, device_in_reset});
        core_supply_ok = 1'b1;
        wait_rst(1'b0);
        clock_supply_ok = 1'b0;
        wait_rst(1'b1);
        clock_supply_ok = 1'b1;
        wait_rst(1'b0);
        core_supply_ok = 1'b0;
        wait_rst(1'b1);
        monitor_enable = 1'b0;
        boot(4'h5);
        user_cfg_request = 1'b1;
        for (int i = 0; i < 10 && cfg_source !== RBM_SRC_USER; i++)
            @(negedge mclk);
        chk("user", {1'b0, RBM_SRC_USER}, {1'b0, cfg_source});
        user_cfg_request = 1'b0;
    endtask

    initial begin
        core_supply_ok = 1'b1;
        clock_supply_ok = 1'b1;
        repeat (20) @(negedge mclk);
        t_reset();
        rstn = 1'b1;
        t_modes();
        t_load(1'b0);
        t_load(1'b1);
        t_monitor();
        wrap_up();
    end
endmodule

// ### verilog/rbm_mode_capture.sv
`timescale 1ns/1ns
module rbm_mode_capture
    import rbm_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Release strobe and synchronised pins
    input wire logic release_pulse,
    input wire logic in_reset,
    input wire logic [3:0] boot_select_sync,
    // Decoded mode
    rbm_mode_if.capture mode
);
    import rbm_pkg::*;

    logic [3:0] code;
    logic valid;

    // Caught on release only, so later pin changes are ignored
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            code <= RBM_MODE_RST;
            valid <= 1'b0;
        end else if (release_pulse) begin
            code <= boot_select_sync;
            valid <= 1'b1;
        end else if (in_reset) begin
            valid <= 1'b0;
        end
    end

    assign mode.code = code;
    assign mode.valid = valid;
    assign mode.is_active = valid && code <= RBM_SA_HI;
    assign mode.is_passive = valid && code >= RBM_SP_LO
        && code <= RBM_SP_HI;
    assign mode.is_test = valid && code == RBM_TEST;
    assign mode.cpol = code[RBM_POL_BIT];
    assign mode.cpha = code[RBM_PHA_BIT];

    a_code_held: assert property (
        @(posedge mclk) disable iff (!rstn)
        !release_pulse |=> $stable(code))
        else $error("captured code changed without release");
    a_code_taken: assert property (
        @(posedge mclk) disable iff (!rstn)
        release_pulse |=> code == $past(boot_select_sync))
        else $error("code not captured at release");
endmodule

// ### verilog/rbm_top.sv
`timescale 1ns/1ns
// How it works
// - Reset pin low holds device in reset
// - Monitor disabled: reset follows pin only
// - Monitor enabled: need pin high, supplies good
// - Supply drop forces reset when monitoring
// - Monitor enable pulled low when open
// - Capture boot pins on reset release
// - Codes 0-3 serial active, polarity/phase
// - Codes 4-7 serial passive, polarity/phase
// - Code 1100 selects test port
// - Active mode: device reads external flash
// - User logic may feed configuration too
// - Serial pins bidirectional only in active mode
// - Status pins defined already during reset
// - Active mode starts reading at release
// - Done/fail lines report load status
module rbm_top
    import rbm_pkg::*;
#(
    parameter int FAIL_CYC = RBM_FAIL_CYC
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Reset pins and supply monitor
    input wire logic reset_pin_n,
    input wire logic monitor_enable,
    input wire logic core_supply_ok,
    input wire logic clock_supply_ok,
    // Boot selection
    input wire logic [3:0] boot_select_pins,
    // Configuration engine status
    input wire logic user_cfg_request,
    input wire logic load_ok,
    input wire logic load_error,
    // Device state
    output logic device_in_reset,
    output logic [3:0] captured_mode,
    output rbm_pkg::rbm_src_t cfg_source,
    output logic serial_cpol,
    output logic serial_cpha,
    output logic flash_read_start,
    // Serial pin direction control
    output logic serial_pins_bidir,
    // Status pins
    output logic load_complete,
    output logic load_fail_n_o,
    output logic load_fail_n_oe,
    output logic serial_forward_out,
    output logic test_data_output_pin
);
    import rbm_pkg::*;

    // The fail pulse must be long, and its counter is sixteen bits wide
    if (FAIL_CYC < 9 || FAIL_CYC > 65535) begin : g_bad_fail_cyc
        $error("FAIL_CYC must lie between 9 and 65535");
    end

    logic [1:0] pin_s, men_s, core_s, clk_s;
    logic [3:0] boot_s1, boot_s2;
    logic in_reset_q;
    logic next_in_reset;
    logic release_pulse;
    logic supplies_ok;
    rbm_state_t state;
    rbm_state_t next_state;
    logic [15:0] fail_cnt;
    logic fail_run;
    logic load_entry;

    rbm_mode_if mode_bus ();

    // Two stages for every pin before any logic reads it
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_s <= 2'h0;
            men_s <= 2'h0;
            core_s <= 2'h0;
            clk_s <= 2'h0;
            boot_s1 <= 4'h0;
            boot_s2 <= 4'h0;
        end else begin
            pin_s <= {pin_s[0], reset_pin_n};
            men_s <= {men_s[0], monitor_enable};
            core_s <= {core_s[0], core_supply_ok};
            clk_s <= {clk_s[0], clock_supply_ok};
            boot_s1 <= boot_select_pins;
            boot_s2 <= boot_s1;
        end
    end

    // An undriven enable settles low off-chip, so it reads as disabled
    assign supplies_ok = core_s[1] && clk_s[1];
    // Pin low always resets; monitor only counts when enabled
    assign next_in_reset = !pin_s[1]
        || (men_s[1] && !supplies_ok);
    assign release_pulse = in_reset_q && !next_in_reset;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            in_reset_q <= 1'b1;
        end else begin
            in_reset_q <= next_in_reset;
        end
    end

    rbm_mode_capture u_capture (
        .mclk(mclk),
        .rstn(rstn),
        .release_pulse(release_pulse),
        .in_reset(in_reset_q),
        .boot_select_sync(boot_s2),
        .mode(mode_bus.capture)
    );

    // Load status sequencer
    always_comb begin
        next_state = state;
        case (state)
            RBM_ST_RESET: begin
                if (release_pulse) begin
                    next_state = RBM_ST_LOAD;
                end
            end
            RBM_ST_LOAD: begin
                if (load_error) begin
                    next_state = RBM_ST_FAIL;
                end else if (load_ok) begin
                    next_state = RBM_ST_DONE;
                end
            end
            RBM_ST_DONE: next_state = RBM_ST_DONE;
            RBM_ST_FAIL: next_state = RBM_ST_FAIL;
            default: next_state = RBM_ST_RESET;
        endcase
        // Keyed on the next level so the release cycle can leave RESET
        if (next_in_reset) begin
            next_state = RBM_ST_RESET;
        end
    end

    assign fail_run = state == RBM_ST_FAIL && fail_cnt != 16'h0;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= RBM_ST_RESET;
            fail_cnt <= 16'h0;
            load_entry <= 1'b0;
        end else begin
            state <= next_state;
            load_entry <= state == RBM_ST_RESET
                && next_state == RBM_ST_LOAD;
            if (next_state == RBM_ST_FAIL && state != RBM_ST_FAIL) begin
                fail_cnt <= 16'(FAIL_CYC);
            end else if (fail_run) begin
                fail_cnt <= fail_cnt - 16'h1;
            end
        end
    end

    // Registered outputs; status pins hold their reset values in reset
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            device_in_reset <= 1'b1;
            captured_mode <= RBM_MODE_RST;
            cfg_source <= RBM_SRC_NONE;
            serial_cpol <= 1'b0;
            serial_cpha <= 1'b0;
            flash_read_start <= 1'b0;
            serial_pins_bidir <= 1'b0;
            load_complete <= 1'b0;
            load_fail_n_o <= 1'b0;
            load_fail_n_oe <= 1'b0;
            serial_forward_out <= 1'b0;
            test_data_output_pin <= 1'b0;
        end else begin
            device_in_reset <= in_reset_q;
            captured_mode <= mode_bus.code;
            serial_cpol <= mode_bus.cpol;
            serial_cpha <= mode_bus.cpha;
            if (user_cfg_request && mode_bus.valid) begin
                cfg_source <= RBM_SRC_USER;
            end else if (mode_bus.is_active) begin
                cfg_source <= RBM_SRC_ACTIVE;
            end else if (mode_bus.is_passive) begin
                cfg_source <= RBM_SRC_PASSIVE;
            end else if (mode_bus.is_test) begin
                cfg_source <= RBM_SRC_TEST;
            end else begin
                cfg_source <= RBM_SRC_NONE;
            end
            // One pulse, one cycle after capture, no reference clock needed
            flash_read_start <= mode_bus.is_active && load_entry;
            serial_pins_bidir <= mode_bus.is_active;
            load_complete <= !in_reset_q && (state == RBM_ST_DONE
                || state == RBM_ST_FAIL);
            // Open drain: only ever drive low, released otherwise
            load_fail_n_oe <= fail_run && !in_reset_q;
            load_fail_n_o <= 1'b0;
            serial_forward_out <= 1'b0;
            test_data_output_pin <= 1'b0;
        end
    end

    a_pin_low_reset: assert property (
        @(posedge mclk) disable iff (!rstn)
        !pin_s[1] |=> in_reset_q)
        else $error("pin low did not hold reset");
    a_monitor_ignored: assert property (
        @(posedge mclk) disable iff (!rstn)
        (!men_s[1] && pin_s[1]) |=> !in_reset_q)
        else $error("monitor disabled but still in reset");
    a_supply_drop: assert property (
        @(posedge mclk) disable iff (!rstn)
        (men_s[1] && !supplies_ok) |=> in_reset_q)
        else $error("supply drop did not force reset");
    a_drop_reset_out: assert property (
        @(posedge mclk) disable iff (!rstn)
        (men_s[1] && $fell(core_s[1])) |-> ##2 device_in_reset)
        else $error("core drop not seen at output");
    a_reset_state: assert property (
        @(posedge mclk) disable iff (!rstn)
        in_reset_q |-> state == RBM_ST_RESET)
        else $error("sequencer not idle while in reset");
    a_reset_out: assert property (
        @(posedge mclk) disable iff (!rstn)
        device_in_reset == $past(in_reset_q))
        else $error("reset output does not follow reset state");

    a_release_once: assert property (
        @(posedge mclk) disable iff (!rstn)
        release_pulse |=> !release_pulse)
        else $error("release lasted more than one cycle");
    a_mode_out: assert property (
        @(posedge mclk) disable iff (!rstn)
        release_pulse |-> ##2 captured_mode == $past(boot_s2, 2))
        else $error("captured mode not shown after release");
    a_bidir_mode: assert property (
        @(posedge mclk) disable iff (!rstn)
        serial_pins_bidir |-> $past(mode_bus.code) <= RBM_SA_HI)
        else $error("serial pins bidir outside active mode");
    a_source_test: assert property (
        @(posedge mclk) disable iff (!rstn)
        (mode_bus.is_test && !user_cfg_request)
        |=> cfg_source == RBM_SRC_TEST)
        else $error("test port not selected");
    a_user_source: assert property (
        @(posedge mclk) disable iff (!rstn)
        (user_cfg_request && mode_bus.valid)
        |=> cfg_source == RBM_SRC_USER)
        else $error("user source not selected");
    a_passive_src: assert property (
        @(posedge mclk) disable iff (!rstn)
        (mode_bus.is_passive && !user_cfg_request)
        |=> cfg_source == RBM_SRC_PASSIVE)
        else $error("passive mode not selected");
    a_active_src: assert property (
        @(posedge mclk) disable iff (!rstn)
        (mode_bus.is_active && !user_cfg_request)
        |=> cfg_source == RBM_SRC_ACTIVE)
        else $error("active mode not selected");

    a_start_release: assert property (
        @(posedge mclk) disable iff (!rstn)
        (release_pulse && boot_s2 <= RBM_SA_HI)
        |-> ##2 flash_read_start)
        else $error("active mode did not start reading");
    a_start_single: assert property (
        @(posedge mclk) disable iff (!rstn)
        flash_read_start |=> !flash_read_start)
        else $error("read start longer than one cycle");
    a_start_active: assert property (
        @(posedge mclk) disable iff (!rstn)
        flash_read_start |-> serial_pins_bidir)
        else $error("read started outside active mode");

    a_status_reset: assert property (
        @(posedge mclk) disable iff (!rstn)
        device_in_reset |-> !load_complete && !load_fail_n_oe
        && !serial_forward_out && !test_data_output_pin)
        else $error("status pins wrong during reset");
    a_fail_pulse: assert property (
        @(posedge mclk) disable iff (!rstn)
        $rose(state == RBM_ST_FAIL) |=> fail_run[*8])
        else $error("fail pulse too short");
    a_error_wins: assert property (
        @(posedge mclk) disable iff (!rstn)
        (state == RBM_ST_LOAD && load_error && !next_in_reset)
        |=> state == RBM_ST_FAIL)
        else $error("load error not taken");
    a_ok_done: assert property (
        @(posedge mclk) disable iff (!rstn)
        (state == RBM_ST_LOAD && load_ok && !load_error
        && !next_in_reset) |=> state == RBM_ST_DONE)
        else $error("load success not taken");
    a_done_status: assert property (
        @(posedge mclk) disable iff (!rstn)
        (state == RBM_ST_DONE && !in_reset_q)
        |=> load_complete && !load_fail_n_oe)
        else $error("success status wrong");
    a_busy_status: assert property (
        @(posedge mclk) disable iff (!rstn)
        state == RBM_ST_LOAD |=> !load_complete && !load_fail_n_oe)
        else $error("busy status wrong");
    a_fail_low: assert property (
        @(posedge mclk) disable iff (!rstn)
        load_fail_n_oe |-> !load_fail_n_o)
        else $error("fail line driven high");
    a_quiet_pins: assert property (
        @(posedge mclk) disable iff (!rstn)
        !serial_forward_out && !test_data_output_pin)
        else $error("forward or test output not low");
endmodule
